// ===== tb/flash_link_chk.sv
// wire checker for the link between host end and flash end
`include "flash_regs.svh"
`default_nettype none
module flash_link_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe,
   input wire logic hold_n,
   input wire logic wp_n
);
   logic sck_q;
   logic cs_q;
   logic seen_q;
   logic bit_taken;
   logic frame_end;
   logic [4:0] bits_q;
   logic [4:0] last_bits_q;
   logic [11:0] low_q;
   logic [11:0] high_q;
   logic [11:0] last_low_q;
   logic [15:0] shift_q;
   // a bit clocked while paused is sent again, so only released bits count
   assign bit_taken = sck && !sck_q && hold_n && !cs_n;
   assign frame_end = cs_n && !cs_q;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // counters saturate so a long idle never wraps into a short gap
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         low_q <= 12'h000;
         high_q <= 12'h000;
      end
      else
      begin
         low_q <= cs_n ? 12'h000 : low_q + {11'h000, ~&low_q};
         high_q <= cs_n ? high_q + {11'h000, ~&high_q} : 12'h000;
      end
   end
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sck_q <= 1'b0;
         cs_q <= 1'b1;
         bits_q <= 5'h00;
         shift_q <= 16'h0000;
      end
      else
      begin
         sck_q <= sck;
         cs_q <= cs_n;
         bits_q <= cs_n ? 5'h00 : bits_q + {4'h0, bit_taken};
         if (bit_taken)
            shift_q <= {shift_q[14:0], si};
      end
   end
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         seen_q <= 1'b0;
         last_low_q <= 12'h000;
         last_bits_q <= 5'h00;
      end
      else if (frame_end)
      begin
         seen_q <= 1'b1;
         last_low_q <= low_q;
         last_bits_q <= bits_q;
      end
   end
   a_sck_idle_low: assert property (
      cs_n && cs_q |-> !sck) else $error("sck moved outside a frame");
   a_si_steady_high: assert property (
      sck && sck_q |-> $stable(si)) else $error("si changed while sck high");
   a_frame_whole_bytes: assert property (
      frame_end |-> bits_q[2:0] == 3'h0 && bits_q <= 5'h10)
      else $error("frame not ended on a byte boundary");
   a_sleep_opcode: assert property (
      frame_end && bits_q == 5'h08 |-> shift_q[7:0] == `OP_DEEP_SLEEP)
      else $error("one byte frame is not the sleep opcode");
   a_pair_opcode: assert property (
      frame_end && bits_q == 5'h10 |-> shift_q == {`OP_RESET, `OP_RESET_CONFIRM}
         || shift_q[15:8] == `OP_STATUS2_WRITE) else $error("two byte frame malformed");
   a_toggle_pulse: assert property (
      frame_end && bits_q == 5'h00 |-> low_q >= `WAKE_PULSE_MIN_CYC)
      else $error("wake pulse too short");
   a_toggle_gap: assert property (
      !cs_n && cs_q && seen_q && last_bits_q == 5'h00 && last_low_q < `EXIT_DELAY_CYC
         |-> high_q >= `EXIT_DELAY_CYC) else $error("frame too soon after wake pulse");
   a_hold_in_low: assert property (
      $changed(hold_n) |-> !sck) else $error("pause changed while sck high");
   a_pause_releases_so: assert property (
      (!hold_n && !cs_n) [*8] |-> !so_oe) else $error("so driven while paused");
   a_deselect_quiet: assert property (
      cs_n [*4] |-> !so_oe) else $error("so driven while deselected");
endmodule : flash_link_chk
`default_nettype wire

// ===== tb/flash_power_hold_reset_ctrl_tb.sv
// bench: host end and flash end joined, sleep, wake, pause and reset traffic
`include "flash_regs.svh"
`default_nettype none
module flash_power_hold_reset_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk;
   logic rst;
   logic prog_busy;
   logic wel_set;
   logic cmd_valid;
   logic hold_req;
   logic wp_assert;
   flash_pkg::host_cmd_e cmd_kind;
   flash_pkg::host_cmd_e k;
   logic write_enable_latch;
   logic reset_permit;
   logic abort_op;
   logic deep_sleep;
   logic paused;
   logic wp_level;
   logic cmd_ready;
   logic done;
   logic permit_m;
   int n_mismatch;
   int n_tests;
   int n_abort;
   int n_pause;
   int seed;
   int i;
   int a0;
   int p0;
   flash_link_if link ();
   flash_dev_end flash_dev_end_i (.ref_clk(ref_clk), .rst(rst), .link(link),
      .prog_busy(prog_busy), .wel_set(wel_set), .write_enable_latch(write_enable_latch), .reset_permit(reset_permit),
      .abort_op(abort_op), .deep_sleep(deep_sleep), .paused(paused), .wp_level(wp_level));
   flash_host_end flash_host_end_i (.ref_clk(ref_clk), .rst(rst), .link(link),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
      .hold_req(hold_req), .wp_assert(wp_assert), .done(done));
   flash_link_chk flash_link_chk_i (.ref_clk(ref_clk), .rst(rst), .cs_n(link.cs_n),
      .sck(link.sck), .si(link.si), .so(link.so), .so_oe(link.so_oe),
      .hold_n(link.hold_n), .wp_n(link.wp_n));
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      if (abort_op === 1'b1)
         n_abort <= n_abort + 1;
      if (paused === 1'b1)
         n_pause <= n_pause + 1;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   // starts after a falling edge, returns at the falling edge that shows done
   task automatic send(input flash_pkg::host_cmd_e kind);
      int n;
      @(posedge ref_clk);
      cmd_kind <= kind;
      cmd_valid <= 1'b1;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      n = 0;
      @(negedge ref_clk);
      while (done !== 1'b1 && n < 4000)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 4000)
         check("done", 8'h00, 8'h01);
   endtask : send
   // pause ends well before the frame would, so deselect never meets it
   task automatic pause_pulse();
      repeat (20 + $unsigned($random(seed)) % 40) @(posedge ref_clk);
      hold_req <= 1'b1;
      wp_assert <= 1'b1;
      repeat (30 + $unsigned($random(seed)) % 30) @(posedge ref_clk);
      @(negedge ref_clk);
      check("wp_level", {7'h00, wp_level}, 8'h01);
      @(posedge ref_clk);
      hold_req <= 1'b0;
      wp_assert <= 1'b0;
   endtask : pause_pulse
   function automatic flash_pkg::host_cmd_e pick(input int r);
      case (r)
         0: return flash_pkg::cmd_permit_on;
         1: return flash_pkg::cmd_permit_off;
         default: return flash_pkg::cmd_reset;
      endcase
   endfunction : pick
   function automatic logic next_permit(input flash_pkg::host_cmd_e c, input logic p);
      if (c == flash_pkg::cmd_permit_on)
         return 1'b1;
      if (c == flash_pkg::cmd_permit_off)
         return 1'b0;
      return p;
   endfunction : next_permit
   task automatic check_defaults();
      check("defaults", {5'h00, write_enable_latch, reset_permit, deep_sleep}, 8'h00);
   endtask : check_defaults
   initial
   begin
      #4000000;
      n_mismatch++;
      print_verdict();
   end
   initial
   begin
      seed = 83;
      rst = 1'b1;
      prog_busy = 1'b0;
      wel_set = 1'b0;
      cmd_valid = 1'b0;
      hold_req = 1'b0;
      wp_assert = 1'b0;
      cmd_kind = flash_pkg::cmd_sleep;
      n_mismatch = 0;
      n_tests = 0;
      n_abort = 0;
      n_pause = 0;
      permit_m = 1'b0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      check("power up", {5'h00, write_enable_latch, reset_permit, deep_sleep}, 8'h00);
      // reset with and without permit, some frames paused
      for (i = 0; i < 10; i++)
      begin
         k = pick(i == 0 ? 2 : i == 1 ? 0 : i == 2 ? 2 : int'($unsigned($random(seed)) % 3));
         a0 = n_abort;
         p0 = n_pause;
         @(posedge ref_clk);
         wel_set <= 1'b1;
         prog_busy <= 1'($random(seed));
         @(posedge ref_clk);
         wel_set <= 1'b0;
         @(negedge ref_clk);
         fork
            send(k);
            if (i % 2 == 1)
               pause_pulse();
         join
         check("abort", 8'(n_abort - a0), {7'h00, k == flash_pkg::cmd_reset && permit_m});
         if (k == flash_pkg::cmd_reset)
            check("wel", {7'h00, write_enable_latch}, {7'h00, !permit_m});
         permit_m = next_permit(k, permit_m);
         check("permit", {7'h00, reset_permit}, {7'h00, permit_m});
         if (i % 2 == 1)
            check("paused", {7'h00, n_pause > p0}, 8'h01);
      end
      send(flash_pkg::cmd_permit_on);
      @(posedge ref_clk);
      prog_busy <= 1'b1;
      send(flash_pkg::cmd_sleep);
      check("busy sleep", {7'h00, deep_sleep}, 8'h00);
      @(posedge ref_clk);
      prog_busy <= 1'b0;
      send(flash_pkg::cmd_sleep);
      check("sleep", {7'h00, deep_sleep}, 8'h01);
      a0 = n_abort;
      send(flash_pkg::cmd_permit_off);
      send(flash_pkg::cmd_reset);
      check("asleep", {6'h00, reset_permit, deep_sleep}, 8'h03);
      check("asleep abort", 8'(n_abort - a0), 8'h00);
      send(flash_pkg::cmd_wake_toggle);
      check("toggle wake", {7'h00, deep_sleep}, 8'h00);
      send(flash_pkg::cmd_permit_off);
      check("after toggle", {7'h00, reset_permit}, 8'h00);
      send(flash_pkg::cmd_sleep);
      send(flash_pkg::cmd_wake_low);
      check("low wake", {7'h00, deep_sleep}, 8'h00);
      send(flash_pkg::cmd_permit_on);
      check("after low wake", {7'h00, reset_permit}, 8'h01);
      send(flash_pkg::cmd_sleep);
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      check_defaults();
      print_verdict();
   end
endmodule : flash_power_hold_reset_ctrl_tb
`default_nettype wire

// ===== verilog/flash_dev_end.sv
// flash end: deep sleep entry and exits, pause of the link, software reset
`include "flash_regs.svh"
`default_nettype none
module flash_dev_end (
   input wire logic ref_clk,
   input wire logic rst,
   flash_link_if.dev link,
   input wire logic prog_busy,
   input wire logic wel_set,
   output logic write_enable_latch,
   output logic reset_permit,
   output logic abort_op,
   output logic deep_sleep,
   output logic paused,
   output logic wp_level
);
   logic [4:0] meta_q;
   logic [4:0] sync_q;
   logic sck_prev_q;
   logic cs_prev_q;
   logic cs_act;
   logic sck_s;
   logic si_s;
   logic hold_act;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic take_bit;
   logic pause_q;
   logic [7:0] shift_q;
   logic [2:0] bit_cnt_q;
   logic [1:0] byte_cnt_q;
   logic [7:0] op_q;
   logic [7:0] arg_q;
   logic ignore_q;
   logic heard;
   logic whole;
   logic two_bytes;
   logic [15:0] tmr_q;
   flash_pkg::dev_state_e state_q;
   logic wel_q;
   logic permit_q;
   logic abort_q;
   logic do_reset;
   logic do_permit;
   logic hold_abort;

   // every pin crosses two flops before use
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         // idle pin levels: deselected, sck low, pause and protect released,
         // so no false sck edge follows reset
         meta_q <= 5'h13;
         sync_q <= 5'h13;
      end
      else
      begin
         meta_q <= {link.cs_n, link.sck, link.si, link.hold_n, link.wp_n};
         sync_q <= meta_q;
      end
   end

   assign cs_act = !sync_q[4];
   assign sck_s = sync_q[3];
   assign si_s = sync_q[2];
   assign hold_act = !sync_q[1];

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b0;
      end
      else
      begin
         sck_prev_q <= sck_s;
         cs_prev_q <= cs_act;
      end
   end

   assign cs_fall = cs_act && !cs_prev_q;
   assign cs_rise = !cs_act && cs_prev_q;
   assign sck_rise = sck_s && !sck_prev_q;

   // pause follows the pin only in sck low
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         pause_q <= 1'b0;
      else if (!cs_act)
         pause_q <= 1'b0;
      else if (!sck_s)
         pause_q <= hold_act;
   end

   // paused link ignores clock and data
   assign take_bit = cs_act && sck_rise && !pause_q;

   // msb first shift, bit and byte count
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         shift_q <= 8'h00;
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 2'h0;
         op_q <= `OP_NONE;
         arg_q <= `OP_NONE;
      end
      else if (cs_fall)
      begin
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 2'h0;
         op_q <= `OP_NONE;
         arg_q <= `OP_NONE;
      end
      else if (take_bit)
      begin
         shift_q <= {shift_q[6:0], si_s};
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (bit_cnt_q == 3'h7)
         begin
            // bytes past the second are dropped
            if (byte_cnt_q == 2'h0)
               op_q <= {shift_q[6:0], si_s};
            else if (byte_cnt_q == 2'h1)
               arg_q <= {shift_q[6:0], si_s};
            if (byte_cnt_q != 2'h3)
               byte_cnt_q <= byte_cnt_q + 2'h1;
         end
      end
   end

   // a frame begun outside standby is acted on only if begun in sleep with select held low through the exit delay
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ignore_q <= 1'b0;
      // frames starting while not in standby
      else if (cs_fall)
         ignore_q <= (state_q != flash_pkg::st_standby);
      // an early first bit marks the frame ignored until the exit delay ends
      else if (take_bit && state_q == flash_pkg::st_wake_low)
         ignore_q <= 1'b1;
      else if (state_q == flash_pkg::st_wake_low && tmr_q == 16'(`EXIT_DELAY_CYC - 1))
         ignore_q <= 1'b0;
   end

   assign heard = !ignore_q && state_q == flash_pkg::st_standby;
   assign whole = (bit_cnt_q == 3'h0);
   assign two_bytes = (byte_cnt_q >= 2'h2);

   assign do_reset = cs_rise && heard && whole && two_bytes && permit_q
      && op_q == `OP_RESET && arg_q == `OP_RESET_CONFIRM;
   assign do_permit = cs_rise && heard && whole && two_bytes && op_q == `OP_STATUS2_WRITE;
   // deselect with pause pin still held
   assign hold_abort = cs_rise && hold_act;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= flash_pkg::st_standby;
         tmr_q <= 16'h0000;
      end
      else
      begin
         case (state_q)
            flash_pkg::st_standby:
            begin
               tmr_q <= 16'h0000;
               if (cs_rise && heard && byte_cnt_q != 2'h0 && op_q == `OP_DEEP_SLEEP
                  && !prog_busy)
                  state_q <= flash_pkg::st_enter;
            end
            flash_pkg::st_enter:
            begin
               tmr_q <= tmr_q + 16'h0001;
               // sleep reached within the entry delay
               if (tmr_q >= 16'(`ENTRY_DELAY_CYC - 1))
                  state_q <= flash_pkg::st_sleep;
            end
            flash_pkg::st_sleep:
            begin
               tmr_q <= 16'h0000;
               if (cs_fall)
                  state_q <= flash_pkg::st_wake_low;
            end
            flash_pkg::st_wake_low:
            begin
               tmr_q <= tmr_q + 16'h0001;
               if (cs_rise)
               begin
                  tmr_q <= 16'h0000;
                  // pulse shorter than the minimum does not wake
                  if (tmr_q >= 16'(`WAKE_PULSE_MIN_CYC - 1))
                     state_q <= flash_pkg::st_exit;
                  else
                     state_q <= flash_pkg::st_sleep;
               end
               // select held low through the exit delay
               else if (tmr_q >= 16'(`EXIT_DELAY_CYC - 1))
                  state_q <= flash_pkg::st_standby;
            end
            flash_pkg::st_exit:
            begin
               tmr_q <= tmr_q + 16'h0001;
               // standby once the exit delay is spent
               if (tmr_q >= 16'(`EXIT_DELAY_CYC - 1))
                  state_q <= flash_pkg::st_standby;
            end
            default:
               state_q <= flash_pkg::st_standby;
         endcase
      end
   end

   // reset is the power cycle: defaults everywhere
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         wel_q <= `WEL_RESET_VALUE;
      // set wins over a clear in the same cycle
      else if (wel_set && state_q == flash_pkg::st_standby)
         wel_q <= 1'b1;
      // abort paths clear the write latch
      else if (do_reset || hold_abort)
         wel_q <= `WEL_RESET_VALUE;
   end

   // software reset leaves the permit bit alone
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         permit_q <= `PERMIT_RESET_VALUE;
      else if (do_permit)
         permit_q <= arg_q[`PERMIT_BIT];
   end

   // abort issued at deselect, well inside the latency
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         abort_q <= 1'b0;
      else
         abort_q <= do_reset || hold_abort;
   end

   // prog_busy is never gated by pause
   assign write_enable_latch = wel_q;
   assign reset_permit = permit_q;
   assign abort_op = abort_q;
   assign deep_sleep = (state_q != flash_pkg::st_standby);
   assign paused = pause_q;
   // write protect still followed while paused
   assign wp_level = !sync_q[0];
   // no read data in this block: so is driven low only while selected
   assign link.so = 1'b0;
   // so released during pause and sleep
   assign link.so_oe = cs_act && !pause_q && state_q == flash_pkg::st_standby;
endmodule : flash_dev_end
`default_nettype wire

// ===== verilog/flash_host_end.sv
// host end: issues sleep, wake, permit and reset frames with a divided sck
`include "flash_regs.svh"
`default_nettype none
module flash_host_end (
   input wire logic ref_clk,
   input wire logic rst,
   flash_link_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire flash_pkg::host_cmd_e cmd_kind,
   input wire logic hold_req,
   input wire logic wp_assert,
   output logic done
);
   flash_pkg::host_state_e state_q;
   logic [15:0] tmr_q;
   logic [15:0] lead_q;
   logic [15:0] gap_q;
   logic [15:0] frame_q;
   logic [4:0] nbits_q;
   logic [2:0] div_q;
   logic cs_n_q;
   logic si_q;
   logic hold_n_q;
   logic done_q;

   // pause pin changes mid sck low so the far end sees it in a low phase
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         hold_n_q <= 1'b1;
      else if (div_q == 3'h1)
         hold_n_q <= !hold_req;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= flash_pkg::h_idle;
         tmr_q <= 16'h0000;
         lead_q <= 16'h0000;
         gap_q <= 16'h0000;
         frame_q <= 16'h0000;
         nbits_q <= 5'h00;
         div_q <= 3'h0;
         cs_n_q <= 1'b1;
         si_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         case (state_q)
            flash_pkg::h_idle:
            begin
               tmr_q <= 16'h0000;
               div_q <= 3'h0;
               if (cmd_valid)
               begin
                  state_q <= flash_pkg::h_lead;
                  cs_n_q <= 1'b0;
                  lead_q <= 16'(`HOST_SETUP_CYC);
                  gap_q <= 16'(`HOST_SETUP_CYC);
                  nbits_q <= 5'h10;
                  frame_q <= {`OP_NONE, `OP_NONE};
                  case (cmd_kind)
                     flash_pkg::cmd_sleep:
                     begin
                        frame_q <= {`OP_DEEP_SLEEP, `OP_NONE};
                        nbits_q <= 5'h08;
                        gap_q <= 16'(`ENTRY_DELAY_CYC + `HOST_SETUP_CYC);
                     end
                     flash_pkg::cmd_wake_toggle:
                     begin
                        // select held the least pulse, then exit delay
                        nbits_q <= 5'h00;
                        lead_q <= 16'(`WAKE_PULSE_MIN_CYC + `HOST_SETUP_CYC);
                        gap_q <= 16'(`EXIT_DELAY_CYC + `HOST_SETUP_CYC);
                     end
                     flash_pkg::cmd_wake_low:
                     begin
                        // select held low through the exit delay
                        nbits_q <= 5'h00;
                        lead_q <= 16'(`EXIT_DELAY_CYC + `HOST_SETUP_CYC);
                     end
                     flash_pkg::cmd_reset:
                     begin
                        // opcode and confirmation back to back
                        frame_q <= {`OP_RESET, `OP_RESET_CONFIRM};
                        gap_q <= 16'(`RESET_LATENCY_CYC + `HOST_SETUP_CYC);
                     end
                     flash_pkg::cmd_permit_on:
                        // permit is set before any program
                        frame_q <= {`OP_STATUS2_WRITE, 8'(1 << `PERMIT_BIT)};
                     flash_pkg::cmd_permit_off:
                        frame_q <= {`OP_STATUS2_WRITE, 8'h00};
                     default:
                        nbits_q <= 5'h00;
                  endcase
               end
            end
            flash_pkg::h_lead:
            begin
               tmr_q <= tmr_q + 16'h0001;
               if (tmr_q >= lead_q)
               begin
                  tmr_q <= 16'h0000;
                  if (nbits_q == 5'h00)
                  begin
                     cs_n_q <= 1'b1;
                     state_q <= flash_pkg::h_gap;
                  end
                  else
                     state_q <= flash_pkg::h_shift;
               end
            end
            flash_pkg::h_shift:
            begin
               div_q <= div_q + 3'h1;
               if (div_q == 3'h0)
                  si_q <= frame_q[15];
               // a paused bit is repeated, never counted
               if (div_q == 3'h7 && hold_n_q)
               begin
                  frame_q <= {frame_q[14:0], 1'b0};
                  nbits_q <= nbits_q - 5'h01;
                  if (nbits_q == 5'h01)
                  begin
                     cs_n_q <= 1'b1;
                     state_q <= flash_pkg::h_gap;
                  end
               end
            end
            flash_pkg::h_gap:
            begin
               div_q <= 3'h0;
               tmr_q <= tmr_q + 16'h0001;
               if (tmr_q >= gap_q)
               begin
                  done_q <= 1'b1;
                  state_q <= flash_pkg::h_idle;
               end
            end
            default:
               state_q <= flash_pkg::h_idle;
         endcase
      end
   end

   assign cmd_ready = (state_q == flash_pkg::h_idle);
   assign done = done_q;
   assign link.cs_n = cs_n_q;
   // sck high in the second half of each eight cycle bit, low when idle
   assign link.sck = (state_q == flash_pkg::h_shift) && div_q[2];
   assign link.si = si_q;
   assign link.hold_n = hold_n_q;
   assign link.wp_n = !wp_assert;
endmodule : flash_host_end
`default_nettype wire

// ===== verilog/flash_link_if.sv
// serial link between the host end and the flash end
`default_nettype none
interface flash_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;
   logic hold_n;
   logic wp_n;
   modport dev (input cs_n, input sck, input si, input hold_n, input wp_n, output so, output so_oe);
   modport host (output cs_n, output sck, output si, output hold_n, output wp_n, input so,
      input so_oe);
endinterface : flash_link_if
`default_nettype wire

// ===== verilog/flash_pkg.sv
// types shared by both ends of the flash link
`default_nettype none
package flash_pkg;
   typedef enum logic [2:0] {st_standby, st_enter, st_sleep, st_wake_low, st_exit} dev_state_e;
   typedef enum logic [1:0] {h_idle, h_lead, h_shift, h_gap} host_state_e;
   typedef enum logic [2:0] {
      cmd_sleep, cmd_wake_toggle, cmd_wake_low, cmd_reset, cmd_permit_on, cmd_permit_off
   } host_cmd_e;
endpackage : flash_pkg
`default_nettype wire

// ===== verilog/flash_regs.svh
// opcodes, field positions and timing counts for the flash power, pause and reset link
`ifndef FLASH_REGS_SVH
`define FLASH_REGS_SVH

`define OP_DEEP_SLEEP 8'h79
`define OP_RESET 8'hF0
`define OP_RESET_CONFIRM 8'hD0
`define OP_STATUS2_WRITE 8'h31
`define OP_NONE 8'h00
`define PERMIT_BIT 4
`define WEL_RESET_VALUE 1'b0
`define PERMIT_RESET_VALUE 1'b0

`define CLK_PERIOD_NS 100
`define WAKE_PULSE_MIN_NS 20000
`define EXIT_DELAY_NS 100000
`define ENTRY_DELAY_NS 3000
`define RESET_LATENCY_NS 60000

// least time rounds up, longest times round down
`define WAKE_PULSE_MIN_CYC ((`WAKE_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXIT_DELAY_CYC (`EXIT_DELAY_NS / `CLK_PERIOD_NS)
`define ENTRY_DELAY_CYC (`ENTRY_DELAY_NS / `CLK_PERIOD_NS)
`define RESET_LATENCY_CYC (`RESET_LATENCY_NS / `CLK_PERIOD_NS)
`define HOST_SETUP_CYC 8

`endif
